/* include/dmp_pkg.sv */
/*
 * Shared constants and types of the DDR memory pin interface.
 * Assumes a single command clock domain plus write data clock domains.
 */
package dmp_pkg;

   // ***************************************************************
   // Widths
   // ***************************************************************
   localparam int DQ_W = 36;
   localparam int HALF_W = 18;
   localparam int LANE_W = 19;
   localparam int PAIR_W = 38;
   localparam int BEAT_W = 37;
   localparam int WORD_W = 74;
   localparam int ADDR_W = 23;
   localparam int BANK_W = 3;
   localparam int COL_W = 4;
   localparam int IDX_W = 7;
   localparam int MEM_DEPTH = 128;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int LANE_MASK_BIT = 18;
   localparam int PAIR_FALL_LSB = 19;
   localparam int BEAT_MASK_BIT = 36;
   localparam int WORD_BEAT1_LSB = 37;

   // ***************************************************************
   // Counts and reset values
   // ***************************************************************
   localparam int READ_LAT = 4;
   localparam int FIFO_DEPTH = 8;
   localparam logic [ADDR_W-1:0] CFG_RESET = 23'h000000;
   localparam logic [DQ_W-1:0] DQ_RESET = 36'h000000000;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      DMP_X9,
      DMP_X18,
      DMP_X36
   } dmp_width_t;

   typedef enum logic [2:0] {
      DMP_CMD_NOP,
      DMP_CMD_READ,
      DMP_CMD_WRITE,
      DMP_CMD_REFRESH,
      DMP_CMD_CFG
   } dmp_cmd_t;

endpackage

/* hw/dmp_fifo.sv */
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
module dmp_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8
)(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [W-1:0] i_data,
   output logic o_valid,
   input wire logic i_ready,
   output logic [W-1:0] o_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
   } dmp_fifo_state_t;

   dmp_fifo_state_t s_reg;
   dmp_fifo_state_t s_next;
   logic [W-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign o_ready = (s_reg.cnt != CW'(DEPTH));
   assign o_valid = (s_reg.cnt != '0);
   assign o_data = mem[s_reg.rd];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   always_comb
   begin
      s_next = s_reg;
      if (push)
      begin
         s_next.wr = s_reg.wr + AW'(1);
      end
      if (pop)
      begin
         s_next.rd = s_reg.rd + AW'(1);
      end
      if (push && !pop)
      begin
         s_next.cnt = s_reg.cnt + CW'(1);
      end
      else if (pop && !push)
      begin
         s_next.cnt = s_reg.cnt - CW'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[s_reg.wr] <= i_data;
      end
   end
endmodule

/* hw/dmp_ddr_capture.sv */
/*
 * Double-edge capture of one write lane group on its write data clock.
 * Assumes the clock runs continuously; the pair is held one full period.
 */
`timescale 1ns/1ps
module dmp_ddr_capture #(
   parameter int W = 19
)(
   input wire logic i_dclk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [2*W-1:0] o_pair,
   output logic o_toggle
);
   typedef struct packed {
      logic [W-1:0] beat;
   } dmp_rise_t;

   typedef struct packed {
      logic [2*W-1:0] pair;
      logic tog;
   } dmp_fall_t;

   dmp_rise_t r_reg;
   dmp_rise_t r_next;
   dmp_fall_t f_reg;
   dmp_fall_t f_next;

   assign o_pair = f_reg.pair;
   assign o_toggle = f_reg.tog;

   // ***************************************************************
   // Beat on each edge, paired on the falling edge
   // ***************************************************************
   always_comb
   begin
      r_next.beat = i_d;
      f_next.pair = {i_d, r_reg.beat};
      f_next.tog = ~f_reg.tog;
   end

   always_ff @(posedge i_dclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         r_reg <= '0;
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   always_ff @(negedge i_dclk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         f_reg <= '0;
      end
      else
      begin
         f_reg <= f_next;
      end
   end
endmodule

/* hw/dmp_pin_interface.sv */
/*
 * Pin-level command, address and data interface of a DDR memory device.
 * Assumes i_clk is the command clock, the controller drives command pins
 * on its rising edge, and both write data clocks run at all times.
 */
`timescale 1ns/1ps

// Behaviour
// - Commands and address latched on command clock rise
// - Address is row/column, or configuration on load
// - Captured bank bits pick the target bank
// - Chip select low enables the command decoder
// - Deselected: ignore new commands, finish running ones
// - Read data beats on both read clock edges
// - Write data beat sampled on each clock edge
// - Wide mode: low half, high half clocks
// - Narrow modes: all data on one clock
// - Masked write beats are discarded, others stored
// - Mask on both edges; high clock when wide
// - Command decoded from write, refresh, chip select
// - Read clocks run freely, aligned to data
// - Wide mode: read clock halves match data halves
// - Read valid flag marks valid driven data
module dmp_pin_interface (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_chip_select_n,
   input wire logic i_write_enable_n,
   input wire logic i_refresh_select_n,
   input wire logic [dmp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dmp_pkg::BANK_W-1:0] i_bank,
   input wire logic [1:0] i_width_select,
   input wire logic i_write_clock_low_half,
   input wire logic i_write_clock_high_half,
   input wire logic [dmp_pkg::DQ_W-1:0] i_dq,
   input wire logic i_write_mask,
   output logic [dmp_pkg::DQ_W-1:0] o_dq,
   output logic o_dq_oe_n,
   output logic o_read_clock_low_half,
   output logic o_read_clock_low_half_n,
   output logic o_read_clock_high_half,
   output logic o_read_clock_high_half_n,
   output logic o_read_valid_flag,
   output logic [dmp_pkg::ADDR_W-1:0] o_config_value,
   output logic o_write_ready
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic cs_n;
      logic we_n;
      logic ref_n;
      logic [dmp_pkg::ADDR_W-1:0] addr;
      logic [dmp_pkg::BANK_W-1:0] bank;
      dmp_pkg::dmp_width_t width;
      logic strap_done;
      logic lo_s1;
      logic lo_s2;
      logic lo_s3;
      logic hi_s1;
      logic hi_s2;
      logic hi_s3;
      logic [dmp_pkg::PAIR_W-1:0] lo_pair;
      logic [dmp_pkg::PAIR_W-1:0] hi_pair;
      logic lo_got;
      logic hi_got;
      logic push_valid;
      logic [dmp_pkg::WORD_W-1:0] push_word;
      logic [dmp_pkg::ADDR_W-1:0] cfg;
      logic [dmp_pkg::READ_LAT-1:0] rd_v;
      logic [dmp_pkg::READ_LAT-1:0][dmp_pkg::IDX_W-1:0] rd_idx;
      logic rd2_v;
      logic [dmp_pkg::IDX_W-1:0] rd2_idx;
      logic qk;
      logic qk_n;
      logic [dmp_pkg::DQ_W-1:0] dq;
      logic dq_oe_n;
      logic vld;
      logic wr_ready;
      logic [3:0] wr_due;
   } dmp_core_t;

   dmp_core_t s_reg;
   dmp_core_t s_next;
   logic [dmp_pkg::DQ_W-1:0] mem_q [dmp_pkg::MEM_DEPTH];

   logic [dmp_pkg::PAIR_W-1:0] lo_link_pair;
   logic [dmp_pkg::PAIR_W-1:0] hi_link_pair;
   logic lo_link_tog;
   logic hi_link_tog;
   logic cmd_in_ready;
   logic cmd_out_valid;
   logic [dmp_pkg::IDX_W-1:0] cmd_out_idx;
   logic dat_in_ready;
   logic dat_out_valid;
   logic [dmp_pkg::WORD_W-1:0] dat_out_word;
   logic drain;
   logic cmd_push;
   dmp_pkg::dmp_cmd_t cmd;
   logic [dmp_pkg::IDX_W-1:0] cmd_idx;
   logic [dmp_pkg::BEAT_W-1:0] beat0;
   logic [dmp_pkg::BEAT_W-1:0] beat1;
   logic lo_evt;
   logic hi_evt;
   logic wide;

   // ***************************************************************
   // Write data capture in the write clock domains
   // ***************************************************************
   dmp_ddr_capture #(
      .W(dmp_pkg::LANE_W)
   ) u_cap_lo (
      .i_dclk(i_write_clock_low_half),
      .i_rst_n(i_rst_n),
      .i_d({i_write_mask, i_dq[dmp_pkg::HALF_W-1:0]}),
      .o_pair(lo_link_pair),
      .o_toggle(lo_link_tog)
   );

   dmp_ddr_capture #(
      .W(dmp_pkg::LANE_W)
   ) u_cap_hi (
      .i_dclk(i_write_clock_high_half),
      .i_rst_n(i_rst_n),
      .i_d({i_write_mask, i_dq[dmp_pkg::DQ_W-1:dmp_pkg::HALF_W]}),
      .o_pair(hi_link_pair),
      .o_toggle(hi_link_tog)
   );

   // ***************************************************************
   // Write command and write data queues
   // ***************************************************************
   dmp_fifo #(
      .W(dmp_pkg::IDX_W),
      .DEPTH(dmp_pkg::FIFO_DEPTH)
   ) u_cmd_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_valid(cmd_push),
      .o_ready(cmd_in_ready),
      .i_data(cmd_idx),
      .o_valid(cmd_out_valid),
      .i_ready(drain),
      .o_data(cmd_out_idx)
   );

   dmp_fifo #(
      .W(dmp_pkg::WORD_W),
      .DEPTH(dmp_pkg::FIFO_DEPTH)
   ) u_dat_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_valid(s_reg.push_valid),
      .o_ready(dat_in_ready),
      .i_data(s_reg.push_word),
      .o_valid(dat_out_valid),
      .i_ready(drain),
      .o_data(dat_out_word)
   );

   assign drain = cmd_out_valid && dat_out_valid;

   // ***************************************************************
   // Command decode
   // ***************************************************************
   always_comb
   begin
      cmd = dmp_pkg::DMP_CMD_NOP;
      if (!s_reg.cs_n)
      begin
         if (!s_reg.we_n && !s_reg.ref_n)
         begin
            cmd = dmp_pkg::DMP_CMD_CFG;
         end
         else if (!s_reg.we_n)
         begin
            cmd = dmp_pkg::DMP_CMD_WRITE;
         end
         else if (!s_reg.ref_n)
         begin
            cmd = dmp_pkg::DMP_CMD_REFRESH;
         end
         else
         begin
            cmd = dmp_pkg::DMP_CMD_READ;
         end
      end
   end

   // Bank bits on top, column bits of the address below
   assign cmd_idx = {s_reg.bank, s_reg.addr[dmp_pkg::COL_W-1:0]};
   assign cmd_push = (cmd == dmp_pkg::DMP_CMD_WRITE) && cmd_in_ready;

   // ***************************************************************
   // Write beat assembly
   // ***************************************************************
   assign wide = (s_reg.width == dmp_pkg::DMP_X36);
   assign lo_evt = s_reg.lo_s2 ^ s_reg.lo_s3;
   assign hi_evt = s_reg.hi_s2 ^ s_reg.hi_s3;

   always_comb
   begin
      if (wide)
      begin
         beat0 = {s_reg.hi_pair[dmp_pkg::LANE_MASK_BIT],
                  s_reg.hi_pair[dmp_pkg::HALF_W-1:0],
                  s_reg.lo_pair[dmp_pkg::HALF_W-1:0]};
         beat1 = {s_reg.hi_pair[dmp_pkg::PAIR_W-1],
                  s_reg.hi_pair[dmp_pkg::PAIR_W-2:dmp_pkg::PAIR_FALL_LSB],
                  s_reg.lo_pair[dmp_pkg::PAIR_W-2:dmp_pkg::PAIR_FALL_LSB]};
      end
      else
      begin
         beat0 = {s_reg.lo_pair[dmp_pkg::LANE_MASK_BIT],
                  {dmp_pkg::HALF_W{1'b0}},
                  s_reg.lo_pair[dmp_pkg::HALF_W-1:0]};
         beat1 = {s_reg.lo_pair[dmp_pkg::PAIR_W-1],
                  {dmp_pkg::HALF_W{1'b0}},
                  s_reg.lo_pair[dmp_pkg::PAIR_W-2:dmp_pkg::PAIR_FALL_LSB]};
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      s_next = s_reg;

      // Pins latched on every rising edge
      s_next.cs_n = i_chip_select_n;
      s_next.we_n = i_write_enable_n;
      s_next.ref_n = i_refresh_select_n;
      s_next.addr = i_addr;
      s_next.bank = i_bank;

      // Width strap caught once after reset release
      if (!s_reg.strap_done)
      begin
         s_next.width = dmp_pkg::dmp_width_t'(i_width_select);
         s_next.strap_done = 1'b1;
      end

      // Toggle synchronisers
      s_next.lo_s1 = lo_link_tog;
      s_next.lo_s2 = s_reg.lo_s1;
      s_next.lo_s3 = s_reg.lo_s2;
      s_next.hi_s1 = hi_link_tog;
      s_next.hi_s2 = s_reg.hi_s1;
      s_next.hi_s3 = s_reg.hi_s2;

      // Pairs are held a full write clock period after the toggle
      if (s_reg.push_valid && dat_in_ready)
      begin
         s_next.push_valid = 1'b0;
      end
      if (s_reg.lo_got && (s_reg.hi_got || !wide))
      begin
         s_next.push_valid = 1'b1;
         s_next.push_word = {beat1, beat0};
         s_next.lo_got = 1'b0;
         s_next.hi_got = 1'b0;
      end
      // Free-running clocks: keep only pairs owed to a queued write
      s_next.wr_due = s_reg.wr_due + 4'(cmd_push) - 4'(s_reg.lo_got && (s_reg.hi_got || !wide));
      if (lo_evt && (s_reg.wr_due != 4'h0))
      begin
         s_next.lo_pair = lo_link_pair;
         s_next.lo_got = 1'b1;
      end
      if (hi_evt && wide && (s_reg.wr_due != 4'h0))
      begin
         s_next.hi_pair = hi_link_pair;
         s_next.hi_got = 1'b1;
      end
      s_next.wr_ready = dat_in_ready && cmd_in_ready;

      // Configuration load takes the address as settings
      if (cmd == dmp_pkg::DMP_CMD_CFG)
      begin
         s_next.cfg = s_reg.addr;
      end

      // Read latency pipeline keeps running while deselected
      s_next.rd_v = {s_reg.rd_v[dmp_pkg::READ_LAT-2:0], cmd == dmp_pkg::DMP_CMD_READ};
      s_next.rd_idx = {s_reg.rd_idx[dmp_pkg::READ_LAT-2:0], cmd_idx};

      // Free-running read clocks, one beat per edge
      s_next.qk = ~s_reg.qk;
      s_next.qk_n = ~s_reg.qk_n;
      if (s_reg.rd_v[dmp_pkg::READ_LAT-1])
      begin
         s_next.dq = mem_q[s_reg.rd_idx[dmp_pkg::READ_LAT-1]];
         s_next.dq_oe_n = 1'b0;
         s_next.vld = 1'b1;
         s_next.rd2_v = 1'b1;
         s_next.rd2_idx = {s_reg.rd_idx[dmp_pkg::READ_LAT-1][dmp_pkg::IDX_W-1:dmp_pkg::COL_W],
                           s_reg.rd_idx[dmp_pkg::READ_LAT-1][dmp_pkg::COL_W-1:0]
                           + dmp_pkg::COL_W'(1)};
      end
      else if (s_reg.rd2_v)
      begin
         s_next.dq = mem_q[s_reg.rd2_idx];
         s_next.dq_oe_n = 1'b0;
         s_next.vld = 1'b1;
         s_next.rd2_v = 1'b0;
      end
      else
      begin
         s_next.dq = dmp_pkg::DQ_RESET;
         s_next.dq_oe_n = 1'b1;
         s_next.vld = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s_reg <= '0;
         s_reg.cs_n <= 1'b1;
         s_reg.we_n <= 1'b1;
         s_reg.ref_n <= 1'b1;
         s_reg.cfg <= dmp_pkg::CFG_RESET;
         s_reg.qk_n <= 1'b1;
         s_reg.dq_oe_n <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ***************************************************************
   // Storage write from the queues
   // ***************************************************************
   always_ff @(posedge i_clk)
   begin
      if (drain)
      begin
         if (!dat_out_word[dmp_pkg::BEAT_MASK_BIT])
         begin
            mem_q[cmd_out_idx] <= dat_out_word[dmp_pkg::DQ_W-1:0];
         end
         if (!dat_out_word[dmp_pkg::WORD_W-1])
         begin
            mem_q[{cmd_out_idx[dmp_pkg::IDX_W-1:dmp_pkg::COL_W],
                   cmd_out_idx[dmp_pkg::COL_W-1:0] + dmp_pkg::COL_W'(1)}]
               <= dat_out_word[dmp_pkg::WORD_BEAT1_LSB+dmp_pkg::DQ_W-1:dmp_pkg::WORD_BEAT1_LSB];
         end
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign o_dq = s_reg.dq;
   assign o_dq_oe_n = s_reg.dq_oe_n;
   assign o_read_clock_low_half = s_reg.qk;
   assign o_read_clock_low_half_n = s_reg.qk_n;
   assign o_read_clock_high_half = s_reg.qk;
   assign o_read_clock_high_half_n = s_reg.qk_n;
   assign o_read_valid_flag = s_reg.vld;
   assign o_config_value = s_reg.cfg;
   assign o_write_ready = s_reg.wr_ready;
endmodule

/* dv/dmp_pin_checker.sv */
/*
 * Assertion checker for the pin interface, bound to its top module.
 * Assumes i_clk is the command clock and i_rst_n an async active-low reset.
 */
`timescale 1ns/1ps
module dmp_pin_checker (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_chip_select_n,
   input wire logic i_write_enable_n,
   input wire logic i_refresh_select_n,
   input wire logic [dmp_pkg::ADDR_W-1:0] i_addr,
   input wire logic [dmp_pkg::DQ_W-1:0] o_dq,
   input wire logic o_dq_oe_n,
   input wire logic o_read_clock_low_half,
   input wire logic o_read_clock_low_half_n,
   input wire logic o_read_clock_high_half,
   input wire logic o_read_clock_high_half_n,
   input wire logic o_read_valid_flag,
   input wire logic [dmp_pkg::ADDR_W-1:0] o_config_value
);
   // ***************************************************************
   // Command decode helpers
   // ***************************************************************
   logic rd_cmd;
   logic cfg_cmd;
   assign rd_cmd = !i_chip_select_n && i_write_enable_n && i_refresh_select_n;
   assign cfg_cmd = !i_chip_select_n && !i_write_enable_n && !i_refresh_select_n;

   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   // ***************************************************************
   // Sequences and properties
   // ***************************************************************
   sequence s_rd_cmd;
      rd_cmd;
   endsequence
   sequence s_cfg_cmd;
      cfg_cmd;
   endsequence
   sequence s_burst;
      o_read_valid_flag && !o_dq_oe_n ##1 o_read_valid_flag && !o_dq_oe_n;
   endsequence

   property p_read_burst;
      s_rd_cmd |-> ##6 s_burst;
   endproperty
   property p_valid_cause;
      o_read_valid_flag |-> $past(rd_cmd, 6) || $past(rd_cmd, 7);
   endproperty
   property p_oe_valid;
      o_dq_oe_n == !o_read_valid_flag;
   endproperty
   property p_dq_idle;
      !o_read_valid_flag |-> o_dq == '0;
   endproperty
   property p_rclk_run;
      $past(i_rst_n) |-> o_read_clock_low_half != $past(o_read_clock_low_half);
   endproperty
   property p_rclk_comp;
      o_read_clock_low_half_n == !o_read_clock_low_half
         && o_read_clock_high_half_n == !o_read_clock_high_half;
   endproperty
   property p_rclk_halves;
      o_read_clock_high_half == o_read_clock_low_half;
   endproperty
   property p_cfg_load;
      s_cfg_cmd |-> ##3 o_config_value == $past(i_addr, 3);
   endproperty
   property p_cfg_hold;
      $changed(o_config_value) |-> $past(cfg_cmd, 1) || $past(cfg_cmd, 2) || $past(cfg_cmd, 3);
   endproperty

   a_read_burst: assert property (p_read_burst)
      else $error("read burst missing or late");
   a_valid_cause: assert property (p_valid_cause)
      else $error("read valid without a selected read");
   a_oe_valid: assert property (p_oe_valid)
      else $error("output enable disagrees with read valid");
   a_dq_idle: assert property (p_dq_idle)
      else $error("data bus not zero while idle");
   a_rclk_run: assert property (p_rclk_run)
      else $error("read clock stopped");
   a_rclk_comp: assert property (p_rclk_comp)
      else $error("read clock complement wrong");
   a_rclk_halves: assert property (p_rclk_halves)
      else $error("read clock halves out of step");
   a_cfg_load: assert property (p_cfg_load)
      else $error("configuration value not loaded");
   a_cfg_hold: assert property (p_cfg_hold)
      else $error("configuration value changed without a load");
endmodule

bind dmp_pin_interface dmp_pin_checker u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_select_n(i_chip_select_n),
   .i_write_enable_n(i_write_enable_n), .i_refresh_select_n(i_refresh_select_n),
   .i_addr(i_addr), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
   .o_read_clock_low_half(o_read_clock_low_half),
   .o_read_clock_low_half_n(o_read_clock_low_half_n),
   .o_read_clock_high_half(o_read_clock_high_half),
   .o_read_clock_high_half_n(o_read_clock_high_half_n),
   .o_read_valid_flag(o_read_valid_flag), .o_config_value(o_config_value)
);

/* dv/dmp_ctrl_model.sv */
/*
 * Controller model: free-running write clock and double-edge write data.
 * Assumes the bench calls send_pair while no other pair is in flight.
 */
`timescale 1ns/1ps
module dmp_ctrl_model (
   output logic o_write_clock,
   output logic [dmp_pkg::DQ_W-1:0] o_dq,
   output logic o_write_mask
);
   // ***************************************************************
   // Write clock, never stopped
   // ***************************************************************
   initial
   begin
      o_write_clock = 1'h0;
      o_dq = 36'h000000000;
      o_write_mask = 1'h1;
      #7;
      forever #32 o_write_clock = ~o_write_clock;
   end

   // ***************************************************************
   // One data pair, a beat per edge
   // ***************************************************************
   task send_pair(input logic [35:0] d0, input logic m0, input logic [35:0] d1,
                  input logic m1);
      @(negedge o_write_clock);
      #2;
      o_dq = d0;
      o_write_mask = m0;
      @(posedge o_write_clock);
      #2;
      o_dq = d1;
      o_write_mask = m1;
      @(negedge o_write_clock);
      #2;
      o_dq = ~d1;
      o_write_mask = ~m1;
   endtask
endmodule

/* dv/dmp_pin_interface_test.sv */
/*
 * Self-checking bench for the pin interface with a controller model.
 * Assumes the model owns the write clock and write data pins.
 */
`timescale 1ns/1ps
module dmp_pin_interface_test;
   logic i_clk = 1'h0;
   logic i_rst_n = 1'h0;
   logic cs_n = 1'h1;
   logic we_n = 1'h1;
   logic ref_n = 1'h1;
   logic [22:0] addr = 23'h000000;
   logic [2:0] bank = 3'h0;
   logic [1:0] wsel = 2'h2;
   logic wclk;
   logic wmask;
   logic [35:0] wdq;
   logic [35:0] rdata;
   logic oe_n;
   logic rck_l;
   logic rck_h;
   logic rvalid;
   logic wready;
   logic [22:0] cfg;
   logic [35:0] mem [128];
   logic [35:0] cmp_m = 36'hfffffffff;
   logic [31:0] seed = 32'h00000009;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   int exp_t[$];
   logic [35:0] exp_d[$];

   always #5 i_clk = ~i_clk;

   dmp_ctrl_model u_ctrl (.o_write_clock(wclk), .o_dq(wdq), .o_write_mask(wmask));

   dmp_pin_interface u_dut (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_chip_select_n(cs_n), .i_write_enable_n(we_n),
      .i_refresh_select_n(ref_n), .i_addr(addr), .i_bank(bank), .i_width_select(wsel),
      .i_write_clock_low_half(wclk), .i_write_clock_high_half(wclk), .i_dq(wdq),
      .i_write_mask(wmask), .o_dq(rdata), .o_dq_oe_n(oe_n), .o_read_clock_low_half(rck_l),
      .o_read_clock_low_half_n(), .o_read_clock_high_half(rck_h),
      .o_read_clock_high_half_n(), .o_read_valid_flag(rvalid), .o_config_value(cfg),
      .o_write_ready(wready)
   );

   // ***************************************************************
   // Helpers
   // ***************************************************************
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function logic [35:0] rnd36();
      return {4'(rnd()), rnd()};
   endfunction

   function logic [6:0] loc(input logic [2:0] b, input logic [3:0] c);
      return {b, c};
   endfunction

   task chk(input string nm, input logic [35:0] seen, input logic [35:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task tally_and_finish();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task cmd(input logic c, input logic w, input logic r, input logic [22:0] a,
            input logic [2:0] b);
      @(posedge i_clk);
      #1;
      cs_n = c;
      we_n = w;
      ref_n = r;
      addr = a;
      bank = b;
   endtask

   task rd(input logic [2:0] b, input logic [3:0] c);
      cmd(1'h0, 1'h1, 1'h1, {19'(rnd()), c}, b);
      exp_t.push_back(cyc + 6);
      exp_d.push_back(mem[loc(b, c)]);
      exp_t.push_back(cyc + 7);
      exp_d.push_back(mem[loc(b, c + 4'h1)]);
      cmd(1'h1, 1'h1, 1'h1, 23'h000000, 3'h0);
   endtask

   task wr(input logic [2:0] b, input logic [3:0] c, input logic [35:0] d0,
           input logic [35:0] d1, input logic m0, input logic m1);
      int k;
      for (k = 0; k < 50 && wready !== 1'h1; k++)
         @(posedge i_clk);
      if (wready !== 1'h1)
      begin
         err_total++;
         tally_and_finish();
      end
      fork
         u_ctrl.send_pair(d0, m0, d1, m1);
         begin
            @(negedge wclk);
            @(posedge wclk);
            cmd(1'h0, 1'h0, 1'h1, {19'(rnd()), c}, b);
            cmd(1'h1, 1'h1, 1'h1, 23'h000000, 3'h0);
         end
      join
      if (!m0)
         mem[loc(b, c)] = d0;
      if (!m1)
         mem[loc(b, c + 4'h1)] = d1;
      repeat (16) @(posedge i_clk);
   endtask

   task do_reset(input logic [1:0] w);
      i_rst_n = 1'h0;
      wsel = w;
      repeat (8) @(posedge i_clk);
      #1;
      i_rst_n = 1'h1;
   endtask

   // ***************************************************************
   // Read beat monitor
   // ***************************************************************
   always @(posedge i_clk)
   begin
      cyc++;
      #2;
      if (exp_t.size() > 0 && exp_t[0] == cyc)
      begin
         chk("read data", rdata & cmp_m, exp_d[0] & cmp_m);
         chk("read valid", rvalid, 1'h1);
         void'(exp_t.pop_front());
         void'(exp_d.pop_front());
      end
      else
         chk("idle valid", rvalid, 1'h0);
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      int i;
      logic [2:0] b;
      logic [3:0] c;
      logic [22:0] ca;
      do_reset(2'h2);
      @(posedge i_clk);
      #1;
      chk("write ready", wready, 1'h1);
      for (i = 0; i < 8; i++)
      begin
         b = 3'(rnd());
         c = (i == 0) ? 4'hf : 4'(rnd());
         wr(b, c, rnd36(), rnd36(), 1'h0, 1'h0);
         rd(b, c);
      end
      wr(3'h1, 4'h3, rnd36(), rnd36(), 1'h0, 1'h0);
      wr(3'h6, 4'h3, rnd36(), rnd36(), 1'h0, 1'h0);
      rd(3'h1, 4'h3);
      rd(3'h6, 4'h3);
      for (i = 1; i < 4; i++)
      begin
         wr(3'h1, 4'h3, rnd36(), rnd36(), i[0], i[1]);
         rd(3'h1, 4'h3);
      end
      ca = 23'(rnd());
      cmd(1'h0, 1'h0, 1'h0, ca, 3'(rnd()));
      cmd(1'h0, 1'h1, 1'h0, 23'(rnd()), 3'h2);
      cmd(1'h1, 1'h1, 1'h1, 23'h000000, 3'h0);
      repeat (4) @(posedge i_clk);
      chk("config value", cfg, ca);
      rd(3'h6, 4'h3);
      for (i = 0; i < 4; i++)
         cmd(1'h1, i[0], i[1], 23'(rnd()), 3'h1);
      cmd(1'h1, 1'h1, 1'h1, 23'h000000, 3'h0);
      repeat (10) @(posedge i_clk);
      chk("config kept", cfg, ca);
      for (i = 0; i < 2; i++)
      begin
         do_reset(i[1:0]);
         cmp_m = (i == 0) ? 36'h0000001ff : 36'h00003ffff;
         wr(3'h5, 4'h7, rnd36(), rnd36(), 1'h0, 1'h0);
         rd(3'h5, 4'h7);
         repeat (10) @(posedge i_clk);
      end
      tally_and_finish();
   end

   initial
   begin
      #900000;
      err_total++;
      tally_and_finish();
   end
endmodule
